// *** uoc_pkg.sv ***
`default_nettype none
package uoc_pkg;
  // register selects on the register port (no offsets are printed)
  localparam logic [2:0] REG_POWER = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_CONTROL = 3'h2;
  localparam logic [2:0] REG_ADDRESS = 3'h3;
  localparam logic [2:0] REG_OTG = 3'h4;
  // power register fields
  localparam int PWR_ACTIVITY_PENDING = 7;
  localparam int PWR_SLEEP_GUARD = 4;
  localparam int PWR_SUSPEND_ENABLE = 1;
  localparam int PWR_OPERATION_ENABLE = 0;
  // status register fields
  localparam int STAT_ENDPOINT_LSB = 4;
  localparam int STAT_DIRECTION = 3;
  localparam int STAT_PINGPONG = 2;
  // control register fields
  localparam int CON_JSTATE = 7;
  localparam int CON_SE0 = 6;
  localparam int CON_PACKET_DISABLE = 5;
  localparam int CON_TOKEN_BUSY = 5;
  localparam int CON_BUS_RESET = 4;
  localparam int CON_HOST_ENABLE = 3;
  localparam int CON_RESUME = 2;
  localparam int CON_PINGPONG_RESET = 1;
  localparam int CON_MODULE_ENABLE = 0;
  localparam int CON_FRAME_START = 0;
  // address register fields
  localparam int ADDR_LOW_SPEED = 7;
  // otg control fields
  localparam int OTG_DP_PULLUP = 7;
  localparam int OTG_DM_PULLUP = 6;
  localparam int OTG_DP_PULLDOWN = 5;
  localparam int OTG_DM_PULLDOWN = 4;
  localparam int OTG_FEATURES_ENABLE = 2;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // timing
  localparam int CLK_HZ = 50000000;
  localparam int FRAME_US = 1000;
  localparam int FRAME_CYCLES = CLK_HZ / 1000000 * FRAME_US;
  localparam int RESUME_MS = 10;
  localparam int BUS_RESET_MS = 50;
  localparam int RESUME_CYCLES = CLK_HZ / 1000 * RESUME_MS;
  localparam int BUS_RESET_CYCLES = CLK_HZ / 1000 * BUS_RESET_MS;
endpackage
`default_nettype wire

// *** uoc_if.sv ***
`default_nettype none
interface uoc_if;
  // register port driven by software end
  logic reg_wr;
  logic reg_rd;
  logic [2:0] reg_sel;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  modport dev (input reg_wr, input reg_rd, input reg_sel, input reg_wdata, output reg_rdata);
  modport sw (output reg_wr, output reg_rd, output reg_sel, output reg_wdata, input reg_rdata);
endinterface
`default_nettype wire

// *** uoc_dev.sv ***
// Operation
// - activity pending reads 1 under guard
// - software sets sleep guard before suspend
// - suspend enable gates usb clock
// - operation enable switches module, resets 0
// - keep enables clear before power off
// - last endpoint updated per transfer
// - direction bit updated with endpoint
// - pingpong bit shows odd bank
// - live single-ended zero flag
// - setup token sets packet disable
// - host enable activates pull-downs
// - resume bit drives resume signalling
// - pingpong reset forces even bank
// - module enable attaches, d+ pull-up
// - live j-state flag in host mode
// - token busy while token executes
// - bus reset bit drives reset signalling
// - frame start token every 1 ms
// - low speed select, host only
// - seven-bit device address, resets zero
// - upper byte reads zero
// - otg enable hands pulls to bits
`default_nettype none
module uoc_dev (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  // register port
  uoc_if.dev bus,
  // transfer engine events
  input wire logic I_XFER_DONE,
  input wire logic [3:0] I_XFER_ENDPOINT,
  input wire logic I_XFER_TX,
  input wire logic I_XFER_ODD,
  input wire logic I_SETUP_SEEN,
  input wire logic I_TOKEN_ACTIVE,
  // bus line state from transceiver pins
  input wire logic I_LINE_SE0,
  input wire logic I_LINE_DIFF,
  input wire logic I_BUS_ACTIVITY,
  // transceiver and engine controls
  output logic O_MODULE_ON,
  output logic O_USB_CLK_GATE,
  output logic O_XCVR_LOW_POWER,
  output logic O_ENGINE_HALT,
  output logic O_PINGPONG_EVEN,
  output logic O_RESUME_DRIVE,
  output logic O_BUS_RESET_DRIVE,
  output logic O_SOF_PULSE,
  output logic O_LOW_SPEED,
  output logic [6:0] O_DEVICE_ADDRESS,
  output logic O_DP_PULLUP,
  output logic O_DM_PULLUP,
  output logic O_DP_PULLDOWN,
  output logic O_DM_PULLDOWN
);
  localparam int FC = uoc_pkg::FRAME_CYCLES;
  localparam int CW = $clog2(FC);
  localparam logic [CW-1:0] FRAME_LAST = CW'(FC - 1);

  typedef struct packed {
    logic [1:0] se0_s;
    logic [1:0] diff_s;
    logic [1:0] act_s;
    logic sleep_guard;
    logic suspend_enable;
    logic operation_enable;
    logic [3:0] last_endpoint;
    logic last_tx;
    logic last_odd;
    logic packet_disable;
    logic bus_reset_request;
    logic host_enable;
    logic resume;
    logic pingpong_reset;
    logic module_enable;
    logic frame_start_enable;
    logic low_speed_enable;
    logic [6:0] device_address;
    logic [7:0] otg_ctl;
    logic [CW-1:0] frame_cnt;
    logic sof;
    logic [7:0] rdata;
  } uoc_dev_state_t;

  uoc_dev_state_t s_q, s_d;
  logic [7:0] wb;
  logic se0, jstate, host_mode;

  // synchronised line state; j-state polarity depends on speed
  assign se0 = s_q.se0_s[1];
  assign host_mode = s_q.host_enable;
  assign jstate = host_mode & ~se0 & (s_q.low_speed_enable ? ~s_q.diff_s[1] : s_q.diff_s[1]);
  assign wb = bus.reg_wdata[7:0];

  always_comb begin
    s_d = s_q;
    s_d.se0_s = {s_q.se0_s[0], I_LINE_SE0};
    s_d.diff_s = {s_q.diff_s[0], I_LINE_DIFF};
    s_d.act_s = {s_q.act_s[0], I_BUS_ACTIVITY};
    s_d.sof = 1'b0;
    // software writes; only the low byte is stored
    if (bus.reg_wr) begin
      unique case (bus.reg_sel)
        uoc_pkg::REG_POWER: begin
          s_d.sleep_guard = wb[uoc_pkg::PWR_SLEEP_GUARD];
          s_d.suspend_enable = wb[uoc_pkg::PWR_SUSPEND_ENABLE];
          s_d.operation_enable = wb[uoc_pkg::PWR_OPERATION_ENABLE];
        end
        uoc_pkg::REG_CONTROL: begin
          s_d.host_enable = wb[uoc_pkg::CON_HOST_ENABLE];
          s_d.resume = wb[uoc_pkg::CON_RESUME];
          s_d.pingpong_reset = wb[uoc_pkg::CON_PINGPONG_RESET];
          if (wb[uoc_pkg::CON_HOST_ENABLE]) begin
            s_d.bus_reset_request = wb[uoc_pkg::CON_BUS_RESET];
            s_d.frame_start_enable = wb[uoc_pkg::CON_FRAME_START];
          end else begin
            s_d.packet_disable = wb[uoc_pkg::CON_PACKET_DISABLE];
            s_d.module_enable = wb[uoc_pkg::CON_MODULE_ENABLE];
          end
        end
        uoc_pkg::REG_ADDRESS: begin
          s_d.low_speed_enable = wb[uoc_pkg::ADDR_LOW_SPEED];
          s_d.device_address = wb[6:0];
        end
        uoc_pkg::REG_OTG: s_d.otg_ctl = wb;
        default: ;
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    if (I_SETUP_SEEN && !host_mode) begin
      s_d.packet_disable = 1'b1;
    end
    // bus activity ends suspend without software
    if (s_q.suspend_enable && s_q.act_s[1]) begin
      s_d.suspend_enable = 1'b0;
    end
    // transfer report
    if (I_XFER_DONE) begin
      s_d.last_endpoint = I_XFER_ENDPOINT;
      s_d.last_tx = I_XFER_TX;
      s_d.last_odd = I_XFER_ODD;
    end
    // 1 ms frame timer, idle while disabled so the first token is a full frame away
    if (host_mode && s_q.frame_start_enable && s_q.operation_enable) begin
      if (s_q.frame_cnt == FRAME_LAST) begin
        s_d.frame_cnt = '0;
        s_d.sof = 1'b1;
      end else begin
        s_d.frame_cnt = s_q.frame_cnt + CW'(1);
      end
    end else begin
      s_d.frame_cnt = '0;
    end
    // registered read data, upper byte always zero
    s_d.rdata = uoc_pkg::RESET_BYTE;
    if (bus.reg_rd) begin
      unique case (bus.reg_sel)
        uoc_pkg::REG_POWER: begin
          s_d.rdata[uoc_pkg::PWR_ACTIVITY_PENDING] = s_q.sleep_guard & s_q.act_s[1];
          s_d.rdata[uoc_pkg::PWR_SLEEP_GUARD] = s_q.sleep_guard;
          s_d.rdata[uoc_pkg::PWR_SUSPEND_ENABLE] = s_q.suspend_enable;
          s_d.rdata[uoc_pkg::PWR_OPERATION_ENABLE] = s_q.operation_enable;
        end
        uoc_pkg::REG_STATUS: begin
          s_d.rdata[uoc_pkg::STAT_ENDPOINT_LSB +: 4] = s_q.last_endpoint;
          s_d.rdata[uoc_pkg::STAT_DIRECTION] = s_q.last_tx;
          s_d.rdata[uoc_pkg::STAT_PINGPONG] = s_q.last_odd;
        end
        uoc_pkg::REG_CONTROL: begin
          s_d.rdata[uoc_pkg::CON_SE0] = se0;
          s_d.rdata[uoc_pkg::CON_HOST_ENABLE] = s_q.host_enable;
          s_d.rdata[uoc_pkg::CON_RESUME] = s_q.resume;
          s_d.rdata[uoc_pkg::CON_PINGPONG_RESET] = s_q.pingpong_reset;
          if (host_mode) begin
            s_d.rdata[uoc_pkg::CON_JSTATE] = jstate;
            s_d.rdata[uoc_pkg::CON_TOKEN_BUSY] = I_TOKEN_ACTIVE;
            s_d.rdata[uoc_pkg::CON_BUS_RESET] = s_q.bus_reset_request;
            s_d.rdata[uoc_pkg::CON_FRAME_START] = s_q.frame_start_enable;
          end else begin
            s_d.rdata[uoc_pkg::CON_PACKET_DISABLE] = s_q.packet_disable;
            s_d.rdata[uoc_pkg::CON_MODULE_ENABLE] = s_q.module_enable;
          end
        end
        uoc_pkg::REG_ADDRESS: begin
          s_d.rdata[uoc_pkg::ADDR_LOW_SPEED] = host_mode & s_q.low_speed_enable;
          s_d.rdata[6:0] = s_q.device_address;
        end
        uoc_pkg::REG_OTG: s_d.rdata = s_q.otg_ctl;
        default: s_d.rdata = uoc_pkg::RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; resume drive, bus reset drive and frame tokens are held off while the module is disabled
  assign bus.reg_rdata = {8'h00, s_q.rdata};
  assign O_MODULE_ON = s_q.operation_enable;
  assign O_USB_CLK_GATE = s_q.suspend_enable;
  assign O_XCVR_LOW_POWER = s_q.suspend_enable | ~s_q.operation_enable;
  assign O_ENGINE_HALT = ~host_mode & s_q.packet_disable;
  assign O_PINGPONG_EVEN = s_q.pingpong_reset;
  assign O_RESUME_DRIVE = s_q.operation_enable & s_q.resume;
  assign O_BUS_RESET_DRIVE = s_q.operation_enable & host_mode & s_q.bus_reset_request;
  assign O_SOF_PULSE = s_q.sof;
  assign O_LOW_SPEED = host_mode & s_q.low_speed_enable;
  assign O_DEVICE_ADDRESS = s_q.device_address;
  // hardware pull control unless otg features take over
  always_comb begin
    if (s_q.otg_ctl[uoc_pkg::OTG_FEATURES_ENABLE]) begin
      O_DP_PULLUP = s_q.otg_ctl[uoc_pkg::OTG_DP_PULLUP];
      O_DM_PULLUP = s_q.otg_ctl[uoc_pkg::OTG_DM_PULLUP];
      O_DP_PULLDOWN = s_q.otg_ctl[uoc_pkg::OTG_DP_PULLDOWN];
      O_DM_PULLDOWN = s_q.otg_ctl[uoc_pkg::OTG_DM_PULLDOWN];
    end else begin
      O_DP_PULLUP = ~s_q.host_enable & s_q.module_enable;
      O_DM_PULLUP = 1'b0;
      O_DP_PULLDOWN = s_q.host_enable;
      O_DM_PULLDOWN = s_q.host_enable;
    end
  end
endmodule
`default_nettype wire

// *** uoc_sw.sv ***
`default_nettype none
module uoc_sw (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  // register port
  uoc_if.sw bus,
  // user requests
  input wire logic I_REQ,
  input wire logic I_REQ_WR,
  input wire logic [2:0] I_REQ_SEL,
  input wire logic [7:0] I_REQ_DATA,
  input wire logic I_START_RESUME,
  input wire logic I_START_BUS_RESET,
  // user answers
  output logic O_BUSY,
  output logic O_RD_VALID,
  output logic [7:0] O_RD_DATA
);
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_READ = 2'b01,
    SW_HOLD = 2'b10,
    SW_TAKE = 2'b11
  } uoc_sw_state_t;

  typedef struct packed {
    uoc_sw_state_t st;
    logic wr;
    logic rd;
    logic [2:0] sel;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic [31:0] hold_cnt;
    logic [7:0] hold_bit;
    logic [7:0] ctl_shadow;
  } uoc_sw_reg_t;

  uoc_sw_reg_t s_q, s_d;

  // single register access per request, timed holds for resume and bus reset
  always_comb begin
    s_d = s_q;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    s_d.rvalid = 1'b0;
    unique case (s_q.st)
      SW_IDLE: begin
        if (I_START_RESUME || I_START_BUS_RESET) begin
          // hold the bit for the timed interval, then clear it
          s_d.hold_bit = I_START_BUS_RESET ? (8'h01 << uoc_pkg::CON_BUS_RESET) : (8'h01 << uoc_pkg::CON_RESUME);
          s_d.hold_cnt = I_START_BUS_RESET ? 32'(uoc_pkg::BUS_RESET_CYCLES) : 32'(uoc_pkg::RESUME_CYCLES);
          s_d.wr = 1'b1;
          s_d.sel = uoc_pkg::REG_CONTROL;
          s_d.wdata = s_q.ctl_shadow | s_d.hold_bit;
          s_d.st = SW_HOLD;
        end else if (I_REQ) begin
          s_d.sel = I_REQ_SEL;
          s_d.wdata = I_REQ_DATA;
          if (I_REQ_WR) begin
            s_d.wr = 1'b1;
            if (I_REQ_SEL == uoc_pkg::REG_CONTROL) begin
              s_d.ctl_shadow = I_REQ_DATA;
            end
          end else begin
            s_d.rd = 1'b1;
            s_d.st = SW_READ;
          end
        end
      end
      // the device registers its read data, so it stands only in the cycle after the strobe
      SW_READ: begin
        s_d.st = SW_TAKE;
      end
      SW_TAKE: begin
        s_d.rdata = bus.reg_rdata[7:0];
        s_d.rvalid = 1'b1;
        s_d.st = SW_IDLE;
      end
      SW_HOLD: begin
        if (s_q.hold_cnt <= 32'h00000001) begin
          s_d.wr = 1'b1;
          s_d.sel = uoc_pkg::REG_CONTROL;
          s_d.wdata = s_q.ctl_shadow & ~s_q.hold_bit;
          s_d.st = SW_IDLE;
        end else begin
          s_d.hold_cnt = s_q.hold_cnt - 32'h00000001;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.reg_wr = s_q.wr;
  assign bus.reg_rd = s_q.rd;
  assign bus.reg_sel = s_q.sel;
  assign bus.reg_wdata = {8'h00, s_q.wdata};
  assign O_BUSY = (s_q.st != SW_IDLE);
  assign O_RD_VALID = s_q.rvalid;
  assign O_RD_DATA = s_q.rdata;
endmodule
`default_nettype wire

// *** uoc_checker.sv ***
`default_nettype none
module uoc_checker (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  // register port signals
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_sel,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RESET);
  logic [7:0] addr_q;
  logic host_q;
  logic op_q;
  // shadow of what software wrote, so reads can be judged without the design's state
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      addr_q <= 8'h00;
      host_q <= 1'b0;
      op_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_sel == uoc_pkg::REG_ADDRESS) addr_q <= reg_wdata[7:0];
      if (reg_sel == uoc_pkg::REG_CONTROL) host_q <= reg_wdata[3];
      if (reg_sel == uoc_pkg::REG_POWER) op_q <= reg_wdata[0];
    end
  end
  // a read request for one select
  sequence s_read(logic [2:0] sel);
    reg_rd && reg_sel == sel;
  endsequence
  a_upper_zero: assert property (reg_rdata[15:8] == 8'h00)
    else $error("upper read byte not zero");
  a_unmapped_zero: assert property (reg_rd && reg_sel > uoc_pkg::REG_OTG |=> reg_rdata == 16'h0000)
    else $error("unmapped select read not zero");
  a_addr_back: assert property (s_read(uoc_pkg::REG_ADDRESS) |=> reg_rdata[6:0] == $past(addr_q[6:0]))
    else $error("device address readback wrong");
  a_speed_host: assert property (s_read(uoc_pkg::REG_ADDRESS) |=> reg_rdata[7] == $past(addr_q[7] & host_q))
    else $error("low speed bit wrong for mode");
  a_op_back: assert property (s_read(uoc_pkg::REG_POWER) |=> reg_rdata[0] == $past(op_q))
    else $error("operation enable readback wrong");
  a_guard_first: assert property (s_read(uoc_pkg::REG_POWER) |=> !reg_rdata[7] || reg_rdata[4])
    else $error("activity pending without guard");
  a_power_holes: assert property (s_read(uoc_pkg::REG_POWER) |=> reg_rdata[6:5] == 2'h0 && reg_rdata[3:2] == 2'h0)
    else $error("unused power bits set");
  a_status_holes: assert property (s_read(uoc_pkg::REG_STATUS) |=> reg_rdata[1:0] == 2'h0)
    else $error("unused status bits set");
  a_device_holes: assert property (s_read(uoc_pkg::REG_CONTROL) ##0 !host_q |=> reg_rdata[7] == 1'b0 && reg_rdata[4] == 1'b0)
    else $error("host-only control bits set in device mode");
endmodule
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, req, req_wr, st_res, st_brst, busy, rd_valid;
  logic [2:0] req_sel;
  logic [7:0] req_data, rd_data;
  logic x_done, x_tx, x_odd, setup, tok, se0, diff, act;
  logic [3:0] x_ep;
  logic on, gate, lowp, halt, even, res_d, brst_d, sof, lspd, dpu, dmu, dpd, dmd;
  logic [6:0] daddr;
  int n_mismatch, checked, cycles, v, k;
  int q_xfer[$];
  uoc_if bus_if ();
  uoc_dev u_uoc_dev (.I_CLK_SYS(clk), .I_RESET(rst), .bus(bus_if.dev), .I_XFER_DONE(x_done),
    .I_XFER_ENDPOINT(x_ep), .I_XFER_TX(x_tx), .I_XFER_ODD(x_odd), .I_SETUP_SEEN(setup), .I_TOKEN_ACTIVE(tok),
    .I_LINE_SE0(se0), .I_LINE_DIFF(diff), .I_BUS_ACTIVITY(act), .O_MODULE_ON(on), .O_USB_CLK_GATE(gate),
    .O_XCVR_LOW_POWER(lowp), .O_ENGINE_HALT(halt), .O_PINGPONG_EVEN(even), .O_RESUME_DRIVE(res_d),
    .O_BUS_RESET_DRIVE(brst_d), .O_SOF_PULSE(sof), .O_LOW_SPEED(lspd), .O_DEVICE_ADDRESS(daddr),
    .O_DP_PULLUP(dpu), .O_DM_PULLUP(dmu), .O_DP_PULLDOWN(dpd), .O_DM_PULLDOWN(dmd));
  uoc_sw u_uoc_sw (.I_CLK_SYS(clk), .I_RESET(rst), .bus(bus_if.sw), .I_REQ(req), .I_REQ_WR(req_wr),
    .I_REQ_SEL(req_sel), .I_REQ_DATA(req_data), .I_START_RESUME(st_res), .I_START_BUS_RESET(st_brst),
    .O_BUSY(busy), .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data));
  uoc_checker u_chk (.I_CLK_SYS(clk), .I_RESET(rst), .reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd),
    .reg_sel(bus_if.reg_sel), .reg_wdata(bus_if.reg_wdata), .reg_rdata(bus_if.reg_rdata));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // inputs always change 1 ns after the edge so no race with the design's flops
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one request to the software end, then wait for it to go idle
  task automatic access(input logic wr, input logic [2:0] sel, input logic [7:0] d);
    req = 1'b1;
    req_wr = wr;
    req_sel = sel;
    req_data = d;
    step(1);
    req = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 20) begin
      step(1);
      k++;
    end
    // a read hands its byte over with a one-cycle valid pulse as the end goes idle
    if (!wr) begin
      chk({7'h00, rd_valid}, 8'h01);
    end
    step(3);
  endtask
  task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
    access(1'b0, sel, 8'h00);
    chk(rd_data, exp);
  endtask
  // clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard: the frame wait dominates the run
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles == 60000) begin
        n_mismatch++;
        close_out();
      end
    end
  end
  initial begin
    {req, req_wr, st_res, st_brst, x_done, x_tx, x_odd, setup, tok, se0, diff, act} = '0;
    req_sel = 3'h0;
    req_data = 8'h00;
    x_ep = 4'h0;
    rst = 1'b1;
    v = $urandom(32'h1502);
    step(20);
    rst = 1'b0;
    step(1);
    for (int s = 0; s < 8; s++) rd(s[2:0], 8'h00);
    chk({6'h00, on, lowp}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      v = $urandom_range(0, 255);
      access(1'b1, 3'h3, v[7:0]);
      rd(3'h3, v[7:0] & 8'h7F);
      chk({1'b0, daddr}, v[7:0] & 8'h7F);
    end
    access(1'b1, 3'h0, 8'h01);
    chk({6'h00, on, lowp}, 8'h02);
    access(1'b1, 3'h0, 8'h13);
    rd(3'h0, 8'h13);
    chk({6'h00, gate, lowp}, 8'h03);
    act = 1'b1;
    step(6);
    rd(3'h0, 8'h91);
    chk({6'h00, gate, lowp}, 8'h00);
    act = 1'b0;
    access(1'b1, 3'h0, 8'h01);
    rd(3'h0, 8'h01);
    for (int i = 0; i < 4; i++) begin
      v = $urandom_range(0, 63);
      q_xfer.push_back(v);
      {x_ep, x_tx, x_odd} = v[5:0];
      x_done = 1'b1;
      step(1);
      x_done = 1'b0;
      step(1);
      rd(3'h1, 8'(q_xfer.pop_front() << 2));
    end
    access(1'b1, 3'h2, 8'h01);
    chk({5'h00, dpu, dpd, dmd}, 8'h04);
    setup = 1'b1;
    step(1);
    setup = 1'b0;
    se0 = 1'b1;
    step(4);
    rd(3'h2, 8'h61);
    chk({7'h00, halt}, 8'h01);
    access(1'b1, 3'h2, 8'h03);
    chk({6'h00, halt, even}, 8'h01);
    se0 = 1'b0;
    access(1'b1, 3'h2, 8'h08);
    chk({4'h0, dpu, dmu, dpd, dmd}, 8'h03);
    access(1'b1, 3'h3, 8'h85);
    rd(3'h3, 8'h85);
    chk({lspd, daddr}, 8'h85);
    tok = 1'b1;
    step(4);
    rd(3'h2, 8'hA8);
    access(1'b1, 3'h3, 8'h05);
    diff = 1'b1;
    step(4);
    rd(3'h2, 8'hA8);
    tok = 1'b0;
    se0 = 1'b1;
    step(4);
    rd(3'h2, 8'h48);
    se0 = 1'b0;
    access(1'b1, 3'h2, 8'h1C);
    chk({6'h00, brst_d, res_d}, 8'h03);
    access(1'b1, 3'h2, 8'h08);
    chk({6'h00, brst_d, res_d}, 8'h00);
    access(1'b1, 3'h4, 8'h84);
    chk({4'h0, dpu, dmu, dpd, dmd}, 8'h08);
    access(1'b1, 3'h4, 8'h00);
    // timed resume from the software end: bit goes up and the end stays busy for the hold
    st_res = 1'b1;
    step(1);
    st_res = 1'b0;
    step(3);
    chk({6'h00, busy, res_d}, 8'h03);
    // reset in mid-run abandons the hold; no power-off write while enables are set
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
    chk({4'h0, busy, res_d, on, lowp}, 8'h01);
    access(1'b1, 3'h0, 8'h01);
    access(1'b1, 3'h2, 8'h09);
    k = 0;
    while (sof !== 1'b1 && k < uoc_pkg::FRAME_CYCLES + 10) begin
      step(1);
      k++;
    end
    chk({7'h00, sof}, 8'h01);
    // one frame from the enable, less the two cycles the write task already spent
    chk(k, uoc_pkg::FRAME_CYCLES - 2);
    // timed bus reset in host mode keeps the frame token enabled
    st_brst = 1'b1;
    step(1);
    st_brst = 1'b0;
    step(3);
    chk({6'h00, busy, brst_d}, 8'h03);
    close_out();
  end
endmodule
`default_nettype wire
